// File: core/serial_control_port_spi.sv
`timescale 1ns/1ns
`include "spi_port_cfg.svh"
// Function
// - Latch three select pins after reset; all low enables SPI, else two-wire.
// - Two-wire slave address is 1001 followed by latched pin pattern.
// - Protocol choice holds until reset; no register can change it.
// - Capture write bits on rising clock, launch read bits on falling clock.
// - Reset state is 3-wire bidirectional, MSB first.
// - 4-wire mode: data pin input only, read data on serial output pin.
// - Chip select high puts both data outputs in high impedance.
// - Byte count 00/01/10 means 1/2/3 bytes, 11 means streaming.
// - Short transfers may stall at byte boundaries; resume on select low.
// - While stalled, hold progress until all expected bytes are done.
// - Select rising off a byte boundary resets port, discards partial data.
// - Streaming moves unlimited bytes, stepping address; select high ends it.
// - Transaction starts with 16-bit instruction then payload.
// - Writes go to buffers; I/O update via 0x0005 bit 0 or pin.
// - Multibyte accesses never skip reserved or blank addresses.
// - Read shifts out N times 8 bits after the instruction.
// - Readback source is buffer or active, chosen by 0x0004 bit 0.
// - Config register 0x0000 lives here, outside the main map.
// - Instruction: MSB read/write, two byte-count bits, 13 address bits.
// - Bit 6 of 0x0000 selects LSB first from the next operation.
// - MSB first decrements address, LSB first increments it.
module serial_control_port_spi
  import spi_port_pkg::*;
#(
  parameter int FIFO_DEPTH = `WR_FIFO_DEPTH
) (
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        port_select_pin_0_i,
  input  wire logic        port_select_pin_1_i,
  input  wire logic        port_select_pin_2_i,
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic        sdio_i,
  output logic             sdio_o,
  output logic             sdio_oe_o,
  output logic             serial_output_pin_o,
  output logic             serial_output_pin_oe_o,
  input  wire logic        io_update_pin_i,
  output logic             spi_enable_o,
  output logic             twi_enable_o,
  output logic [6:0]       twi_address_o,
  output logic             lsb_first_o,
  output logic             unidir_o,
  output wr_word_type      map_wr_o,
  output logic             map_wr_valid_o,
  input  wire logic        map_wr_ready_i,
  output ctrl_type         map_ctrl_o,
  output logic [12:0]      map_rd_addr_o,
  input  wire logic [7:0]  map_rd_data_i
);
  typedef enum logic [3:0] {
    ST_INSTR = 4'h1,
    ST_WRITE = 4'h2,
    ST_READ  = 4'h4,
    ST_DONE  = 4'h8
  } state_type;

  // Two-flop synchronisers for all pin inputs
  logic [1:0] sclk_s, cs_s, sdio_s, upd_s, p0_s, p1_s, p2_s;
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclk_s <= '0;
      cs_s   <= 2'h3;
      sdio_s <= '0;
      upd_s  <= '0;
      p0_s   <= '0;
      p1_s   <= '0;
      p2_s   <= '0;
    end else begin
      sclk_s <= {sclk_s[0], sclk_i};
      cs_s   <= {cs_s[0], cs_n_i};
      sdio_s <= {sdio_s[0], sdio_i};
      upd_s  <= {upd_s[0], io_update_pin_i};
      p0_s   <= {p0_s[0], port_select_pin_0_i};
      p1_s   <= {p1_s[0], port_select_pin_1_i};
      p2_s   <= {p2_s[0], port_select_pin_2_i};
    end
  end

  logic sclk_d_reg, upd_d_reg;
  logic sclk_rise, sclk_fall, cs_high, upd_rise;
  assign cs_high   = cs_s[1];
  assign sclk_rise = sclk_s[1] && !sclk_d_reg;
  assign sclk_fall = !sclk_s[1] && sclk_d_reg;
  assign upd_rise  = upd_s[1] && !upd_d_reg;

  // Strap capture a few cycles after reset release
  logic [1:0] strap_cnt_reg, strap_cnt_next;
  logic       strap_done_reg, strap_done_next;
  logic [2:0] strap_reg, strap_next;

  logic [7:0]  cfg_reg, cfg_next;
  logic        rd_src_reg, rd_src_next;
  logic        lsb_reg, lsb_next;
  state_type   st_reg, st_next;
  logic [15:0] sh_reg, sh_next;
  logic [3:0]  bit_reg, bit_next;
  logic        rw_reg, rw_next;
  logic [1:0]  bc_reg, bc_next;
  logic [1:0]  left_reg, left_next;
  logic [12:0] addr_reg, addr_next;
  logic [7:0]  tx_reg, tx_next;
  logic        out_reg, out_next;
  logic        upd_reg, upd_next;
  wr_word_type wq_data;
  logic        wq_valid, flush;

  logic        rx_bit;
  logic [15:0] sh_in;
  logic [12:0] addr_step;
  logic [7:0]  rd_byte;

  assign rx_bit    = sdio_s[1];
  assign addr_step = lsb_reg ? addr_reg + 13'h1 : addr_reg - 13'h1;
  // Readback of 0x0000 and 0x0004 short-circuits the map
  always_comb begin
    rd_byte = map_rd_data_i;
    if (addr_reg == `ADDR_SPI_CONFIG) rd_byte = cfg_reg;
    else if (addr_reg == `ADDR_READ_SOURCE) rd_byte = {7'h00, rd_src_reg};
  end

  always_comb begin
    strap_cnt_next  = strap_cnt_reg;
    strap_done_next = strap_done_reg;
    strap_next      = strap_reg;
    if (!strap_done_reg) begin
      strap_cnt_next = strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == 2'h3) begin
        strap_done_next = 1'b1;
        strap_next      = {p2_s[1], p1_s[1], p0_s[1]};
      end
    end
  end

  always_comb begin
    cfg_next    = cfg_reg;
    rd_src_next = rd_src_reg;
    lsb_next    = lsb_reg;
    st_next     = st_reg;
    sh_next     = sh_reg;
    bit_next    = bit_reg;
    rw_next     = rw_reg;
    bc_next     = bc_reg;
    left_next   = left_reg;
    addr_next   = addr_reg;
    tx_next     = tx_reg;
    out_next    = out_reg;
    upd_next    = upd_rise;
    wq_valid    = 1'b0;
    flush       = 1'b0;
    wq_data.addr = addr_reg;
    // LSB first fills from the top, so the byte sits in the upper bits
    wq_data.data = lsb_reg ? {rx_bit, sh_reg[15:9]} : {sh_reg[6:0], rx_bit};
    sh_in        = lsb_reg ? {rx_bit, sh_reg[15:1]} : {sh_reg[14:0], rx_bit};
    if (!spi_enable_o) begin
      st_next = ST_INSTR;
    end else if (cs_high) begin
      // Mid-byte release aborts; at a boundary progress is kept except when streaming or done
      // Bit 3 ignored so the instruction may also stall after its first byte
      if (bit_reg[2:0] != 3'h0 || st_reg == ST_DONE
          || (bc_reg == `BC_STREAM && st_reg != ST_INSTR)) begin
        if (bit_reg[2:0] != 3'h0 && st_reg == ST_WRITE) flush = 1'b1;
        st_next  = ST_INSTR;
        bit_next = 4'h0;
        lsb_next = cfg_reg[`CFG_LSB_FIRST_BIT];
      end
      if (st_reg == ST_INSTR && bit_reg == 4'h0) lsb_next = cfg_reg[`CFG_LSB_FIRST_BIT];
    end else if (sclk_rise) begin
      unique case (st_reg)
        ST_INSTR: begin
          sh_next  = sh_in;
          bit_next = bit_reg + 4'h1;
          if (bit_reg == 4'hF) begin
            rw_next   = sh_in[`INSTR_RW_BIT];
            bc_next   = sh_in[`INSTR_BC_HI_BIT:`INSTR_BC_LO_BIT];
            left_next = sh_in[`INSTR_BC_HI_BIT:`INSTR_BC_LO_BIT];
            addr_next = sh_in[12:0];
            st_next   = sh_in[`INSTR_RW_BIT] ? ST_READ : ST_WRITE;
          end
        end
        ST_WRITE: begin
          sh_next  = sh_in;
          bit_next = {1'b0, bit_reg[2:0] + 3'h1};
          if (bit_reg[2:0] == 3'h7) begin
            bit_next = 4'h0;
            if (addr_reg == `ADDR_SPI_CONFIG) begin
              cfg_next = wq_data.data;
            end else if (addr_reg == `ADDR_READ_SOURCE) begin
              rd_src_next = wq_data.data[`READ_SOURCE_BIT];
            end else if (addr_reg == `ADDR_IO_UPDATE) begin
              upd_next = wq_data.data[`IO_UPDATE_BIT] | upd_rise;
            end else begin
              wq_valid = 1'b1;
            end
            addr_next = addr_step;
            if (bc_reg != `BC_STREAM) begin
              left_next = left_reg - 2'h1;
              if (left_reg == 2'h0) st_next = ST_DONE;
            end
          end
        end
        ST_READ: begin
          bit_next = {1'b0, bit_reg[2:0] + 3'h1};
          if (bit_reg[2:0] == 3'h7) begin
            bit_next  = 4'h0;
            addr_next = addr_step;
            if (bc_reg != `BC_STREAM) begin
              left_next = left_reg - 2'h1;
              if (left_reg == 2'h0) st_next = ST_DONE;
            end
          end
        end
        ST_DONE: begin
        end
      endcase
    end else if (sclk_fall && st_reg == ST_READ) begin
      // Launch next bit on the falling edge
      if (bit_reg[2:0] == 3'h0) begin
        out_next = lsb_reg ? rd_byte[0] : rd_byte[7];
        tx_next  = lsb_reg ? {1'b0, rd_byte[7:1]} : {rd_byte[6:0], 1'b0};
      end else begin
        out_next = lsb_reg ? tx_reg[0] : tx_reg[7];
        tx_next  = lsb_reg ? {1'b0, tx_reg[7:1]} : {tx_reg[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclk_d_reg     <= 1'b0;
      upd_d_reg      <= 1'b0;
      strap_cnt_reg  <= '0;
      strap_done_reg <= 1'b0;
      strap_reg      <= 3'h7;
      cfg_reg        <= `CFG_RESET_VALUE;
      rd_src_reg     <= 1'b0;
      lsb_reg        <= 1'b0;
      st_reg         <= ST_INSTR;
      sh_reg         <= '0;
      bit_reg        <= '0;
      rw_reg         <= 1'b0;
      bc_reg         <= '0;
      left_reg       <= '0;
      addr_reg       <= '0;
      tx_reg         <= '0;
      out_reg        <= 1'b0;
      upd_reg        <= 1'b0;
    end else begin
      sclk_d_reg     <= sclk_s[1];
      upd_d_reg      <= upd_s[1];
      strap_cnt_reg  <= strap_cnt_next;
      strap_done_reg <= strap_done_next;
      strap_reg      <= strap_next;
      cfg_reg        <= cfg_next;
      rd_src_reg     <= rd_src_next;
      lsb_reg        <= lsb_next;
      st_reg         <= st_next;
      sh_reg         <= sh_next;
      bit_reg        <= bit_next;
      rw_reg         <= rw_next;
      bc_reg         <= bc_next;
      left_reg       <= left_next;
      addr_reg       <= addr_next;
      tx_reg         <= tx_next;
      out_reg        <= out_next;
      upd_reg        <= upd_next;
    end
  end

  wr_fifo #(
    .WIDTH ($bits(wr_word_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .core_clk_i  (core_clk_i),
    .arst_n_i    (arst_n_i),
    .flush_i     (1'b0),
    .in_valid_i  (wq_valid && !flush),
    .in_ready_o  (),
    .in_data_i   (wq_data),
    .out_valid_o (map_wr_valid_o),
    .out_ready_i (map_wr_ready_i),
    .out_data_o  (map_wr_o)
  );

  assign spi_enable_o  = strap_done_reg && (strap_reg == 3'h0);
  assign twi_enable_o  = strap_done_reg && (strap_reg != 3'h0);
  assign twi_address_o = {`TWI_ADDR_HI, strap_reg};
  assign lsb_first_o   = lsb_reg;
  assign unidir_o      = cfg_reg[`CFG_UNIDIR_BIT];
  assign map_rd_addr_o = addr_reg;
  assign map_ctrl_o.io_update   = upd_reg;
  assign map_ctrl_o.read_active = rd_src_reg;

  // Drivers off whenever select is high or not reading; first bit of each byte included
  logic drive;
  assign drive = spi_enable_o && !cs_high
                 && (st_reg == ST_READ || st_reg == ST_DONE && rw_reg);
  assign sdio_o                 = out_reg;
  assign sdio_oe_o              = drive && !cfg_reg[`CFG_UNIDIR_BIT];
  assign serial_output_pin_o    = out_reg;
  assign serial_output_pin_oe_o = drive && cfg_reg[`CFG_UNIDIR_BIT];
endmodule

// File: pkg/spi_port_cfg.svh
`ifndef SPI_PORT_CFG_SVH
`define SPI_PORT_CFG_SVH

// Addresses handled inside the port, and the last map address
`define ADDR_SPI_CONFIG     13'h0000
`define ADDR_READ_SOURCE    13'h0004
`define ADDR_IO_UPDATE      13'h0005
`define ADDR_LAST           13'h1FFF
// Config register fields
`define CFG_LSB_FIRST_BIT   6
`define CFG_UNIDIR_BIT      7
`define CFG_RESET_VALUE     8'h00
`define IO_UPDATE_BIT       0
`define READ_SOURCE_BIT     0
// Two-wire address upper nibble
`define TWI_ADDR_HI         4'h9
// Instruction word layout
`define INSTR_BITS          16
`define INSTR_RW_BIT        15
`define INSTR_BC_HI_BIT     14
`define INSTR_BC_LO_BIT     13
`define BC_STREAM           2'h3
// Fifo depth
`define WR_FIFO_DEPTH       32

`endif

// File: pkg/spi_port_pkg.sv
package spi_port_pkg;

  typedef struct packed {
    logic [12:0] addr;
    logic [7:0]  data;
  } wr_word_type;

  typedef struct packed {
    logic       io_update;
    logic       read_active;
  } ctrl_type;

endpackage

// File: core/wr_fifo.sv
`timescale 1ns/1ns
module wr_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 32
) (
  input  wire logic             core_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  assign in_ready_o  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem_reg[rp_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    wp_next  = wp_reg;
    rp_next  = rp_reg;
    cnt_next = cnt_reg;
    if (flush_i) begin
      wp_next  = '0;
      rp_next  = '0;
      cnt_next = '0;
    end else begin
      if (push) wp_next = (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
      if (pop) rp_next = (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
      if (push && !pop) cnt_next = cnt_reg + 1'b1;
      if (pop && !push) cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage has no reset; contents only read when counted valid
  always_ff @(posedge core_clk_i) begin
    if (push && !flush_i) mem_reg[wp_reg] <= in_data_i;
  end
endmodule

// File: verif/serial_control_port_spi_sva.sv
`timescale 1ns/1ns
module serial_control_port_spi_sva
  import spi_port_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        arst_n_i,
  input wire logic        cs_n_i,
  input wire logic        sdio_oe_o,
  input wire logic        serial_output_pin_oe_o,
  input wire logic        spi_enable_o,
  input wire logic        twi_enable_o,
  input wire logic [6:0]  twi_address_o,
  input wire logic        unidir_o,
  input wire wr_word_type map_wr_o,
  input wire logic        map_wr_valid_o,
  input wire logic        map_wr_ready_i,
  input wire ctrl_type    map_ctrl_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // Five samples cover the two-flop sync with margin; the enables are not registered
  property p_hiz;
    cs_n_i [*5] |-> !sdio_oe_o && !serial_output_pin_oe_o;
  endproperty
  a_hiz: assert property (p_hiz) else $error("data pin driven while deselected");
  property p_spi_sel;
    spi_enable_o |-> !twi_enable_o && twi_address_o == 7'h48;
  endproperty
  a_spi_sel: assert property (p_spi_sel) else $error("spi chosen with pins set");
  property p_twi_addr;
    twi_enable_o |-> twi_address_o[6:3] == 4'h9 && twi_address_o[2:0] != 3'h0;
  endproperty
  a_twi_addr: assert property (p_twi_addr) else $error("bad two-wire address");
  property p_fixed;
    spi_enable_o || twi_enable_o |=> $stable({spi_enable_o, twi_enable_o, twi_address_o});
  endproperty
  a_fixed: assert property (p_fixed) else $error("protocol changed");
  property p_uni;
    unidir_o |-> !sdio_oe_o;
  endproperty
  a_uni: assert property (p_uni) else $error("data pin driven in 4-wire mode");
  property p_bidir;
    !unidir_o |-> !serial_output_pin_oe_o;
  endproperty
  a_bidir: assert property (p_bidir) else $error("output pin driven in 3-wire mode");
  property p_pulse;
    map_ctrl_o.io_update |=> !map_ctrl_o.io_update;
  endproperty
  a_pulse: assert property (p_pulse) else $error("update longer than one cycle");
  property p_hold;
    map_wr_valid_o && !map_wr_ready_i |=> map_wr_valid_o && $stable(map_wr_o);
  endproperty
  a_hold: assert property (p_hold) else $error("queued write not held");
endmodule

bind serial_control_port_spi serial_control_port_spi_sva u_sva (
  .core_clk_i, .arst_n_i, .cs_n_i, .sdio_oe_o, .serial_output_pin_oe_o, .spi_enable_o,
  .twi_enable_o, .twi_address_o, .unidir_o, .map_wr_o, .map_wr_valid_o, .map_wr_ready_i,
  .map_ctrl_o
);

// File: verif/spi_host_model.sv
`timescale 1ns/1ns
module spi_host_model (
  input  wire logic lsb_i,
  input  wire logic four_i,
  input  wire logic sdio_i,
  input  wire logic sdo_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdio_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdio_o = 1'b0;
  end
  // Clock stands still between frames; a released line never keeps its value
  task automatic sel(input logic v);
    cs_n_o = v;
    sdio_o = ~sdio_o;
    #125;
  endtask
  task automatic xfer(input logic [15:0] tx, input int n, input logic rd,
                      output logic [15:0] rx);
    int b;
    rx = '0;
    for (int i = 0; i < n; i++) begin
      b = lsb_i ? i : n - 1 - i;
      sdio_o = rd ? ~sdio_o : tx[b];
      #62;
      sclk_o = 1'b1;
      rx[b] = four_i ? sdo_i : sdio_i;
      #63;
      sclk_o = 1'b0;
    end
  endtask
endmodule

// File: verif/testbench.sv
`timescale 1ns/1ns
module testbench;
  import spi_port_pkg::*;
  logic        core_clk_i, arst_n_i, sclk, cs_n, host_sd, sdio_d, sdio_oe, serial_output_pin;
  logic        io_pin, rdy, lsb, four, spi_en, twi_en, lsb_o, uni_o, wr_v, so_oe;
  logic [2:0]  pins;
  logic [6:0]  twi_addr;
  logic [12:0] rd_addr;
  logic [15:0] rx;
  logic [7:0]  got [40];
  wr_word_type wr_w;
  ctrl_type    ctrl;
  int          bad_count, checks_done;
  wire logic   sdio_w = sdio_oe ? sdio_d : host_sd;
  // Released output pin shows the inverse so an idle driver cannot pass
  wire logic   sdo_w = so_oe ? serial_output_pin : ~serial_output_pin;

  serial_control_port_spi #(.FIFO_DEPTH(32)) uut (
    .core_clk_i, .arst_n_i, .port_select_pin_0_i(pins[0]), .port_select_pin_1_i(pins[1]),
    .port_select_pin_2_i(pins[2]), .sclk_i(sclk), .cs_n_i(cs_n), .sdio_i(sdio_w),
    .sdio_o(sdio_d), .sdio_oe_o(sdio_oe), .serial_output_pin_o(serial_output_pin),
    .serial_output_pin_oe_o(so_oe), .io_update_pin_i(io_pin), .spi_enable_o(spi_en),
    .twi_enable_o(twi_en), .twi_address_o(twi_addr), .lsb_first_o(lsb_o),
    .unidir_o(uni_o), .map_wr_o(wr_w), .map_wr_valid_o(wr_v), .map_wr_ready_i(rdy),
    .map_ctrl_o(ctrl), .map_rd_addr_o(rd_addr), .map_rd_data_i(rd_addr[7:0] ^ 8'h5A)
  );
  spi_host_model host (
    .lsb_i(lsb), .four_i(four), .sdio_i(sdio_w), .sdo_i(sdo_w),
    .sclk_o(sclk), .cs_n_o(cs_n), .sdio_o(host_sd)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic guard(input int i);
    if (i >= 600) begin
      bad_count++;
      end_of_test();
    end
  endtask
  task automatic do_reset(input logic [2:0] p);
    @(negedge core_clk_i);
    arst_n_i = 1'b0;
    pins = p;
    lsb = 1'b0;
    four = 1'b0;
    repeat (2) @(negedge core_clk_i);
    arst_n_i = 1'b1;
    repeat (8) @(negedge core_clk_i);
  endtask
  task automatic access(input logic rw, input logic [1:0] bc, input logic [12:0] a,
                        input int nb, input logic [7:0] d, input logic stall);
    // Offset keeps every link edge clear of the core clock's edges
    @(negedge core_clk_i);
    #2;
    host.sel(1'b0);
    if (stall) begin
      host.xfer({8'h00, rw, bc, a[12:8]}, 8, 1'b0, rx);
      host.sel(1'b1);
      host.sel(1'b0);
      host.xfer({8'h00, a[7:0]}, 8, 1'b0, rx);
    end else begin
      host.xfer({rw, bc, a}, 16, 1'b0, rx);
    end
    for (int k = 0; k < nb; k++) begin
      if (stall) begin
        host.sel(1'b1);
        host.sel(1'b0);
      end
      host.xfer({8'h00, d + 8'(k)}, 8, rw, rx);
      got[k] = rx[7:0];
    end
    host.sel(1'b1);
  endtask
  task automatic pop(input logic [12:0] a, input logic [7:0] d);
    int i;
    @(negedge core_clk_i);
    for (i = 0; i < 600 && wr_v !== 1'b1; i++) @(negedge core_clk_i);
    guard(i);
    chk(32'(wr_w), 32'({a, d}));
    rdy = 1'b1;
    @(negedge core_clk_i);
    rdy = 1'b0;
  endtask
  task automatic empty();
    repeat (20) @(negedge core_clk_i);
    chk(32'(wr_v), 32'h0);
  endtask
  task automatic wait_io();
    int i;
    @(negedge core_clk_i);
    for (i = 0; i < 600 && ctrl.io_update !== 1'b1; i++) @(negedge core_clk_i);
    guard(i);
    chk(32'(ctrl.io_update), 32'h1);
  endtask

  task automatic t_strap();
    do_reset(3'b101);
    chk({twi_en, spi_en, twi_addr}, {2'b10, 7'h4D});
    do_reset(3'b000);
    chk({spi_en, twi_en, lsb_o, uni_o}, 4'b1000);
  endtask
  task automatic t_writes();
    access(1'b0, 2'b00, 13'h0010, 1, 8'h3C, 1'b0);
    pop(13'h0010, 8'h3C);
    empty();
    access(1'b0, 2'b10, 13'h0021, 3, 8'h11, 1'b1);
    for (int k = 0; k < 3; k++) begin
      pop(13'h0021 - 13'(k), 8'h11 + 8'(k));
    end
    empty();
  endtask
  task automatic t_abort();
    @(negedge core_clk_i);
    #2;
    host.sel(1'b0);
    host.xfer(16'h0030, 16, 1'b0, rx);
    host.xfer(16'h00FF, 4, 1'b0, rx);
    host.sel(1'b1);
    access(1'b0, 2'b00, 13'h0031, 1, 8'h77, 1'b0);
    pop(13'h0031, 8'h77);
    empty();
  endtask
  task automatic t_fill();
    // Two extra bytes must be refused once the queue is full
    access(1'b0, 2'b11, 13'h0100, 34, 8'h00, 1'b0);
    for (int k = 0; k < 32; k++) begin
      pop(13'h0100 - 13'(k), 8'(k));
    end
    empty();
  endtask
  task automatic t_read();
    access(1'b1, 2'b01, 13'h0040, 2, 8'h00, 1'b0);
    chk(32'(got[0]), 32'h1A);
    chk(32'(got[1]), 32'h65);
  endtask
  task automatic t_ctrl();
    access(1'b0, 2'b00, 13'h0004, 1, 8'h01, 1'b0);
    chk(32'(ctrl.read_active), 32'h1);
    fork
      access(1'b0, 2'b00, 13'h0005, 1, 8'h01, 1'b0);
      wait_io();
    join
    @(negedge core_clk_i);
    io_pin = 1'b1;
    wait_io();
    io_pin = 1'b0;
    empty();
  endtask
  task automatic t_mode();
    access(1'b0, 2'b00, 13'h0000, 1, 8'hC0, 1'b0);
    chk({lsb_o, uni_o}, 2'b11);
    empty();
    lsb = 1'b1;
    four = 1'b1;
    access(1'b0, 2'b01, 13'h0050, 2, 8'hA0, 1'b0);
    pop(13'h0050, 8'hA0);
    pop(13'h0051, 8'hA1);
    access(1'b1, 2'b00, 13'h0060, 1, 8'h00, 1'b0);
    chk(32'(got[0]), 32'h3A);
  endtask

  initial begin
    arst_n_i = 1'b0;
    pins = 3'b000;
    io_pin = 1'b0;
    rdy = 1'b0;
    lsb = 1'b0;
    four = 1'b0;
    bad_count = 0;
    checks_done = 0;
    t_strap();
    t_writes();
    t_abort();
    t_fill();
    t_read();
    t_ctrl();
    t_mode();
    end_of_test();
  end
endmodule
